// ===== design/ttcu_pkg.sv
// Purpose: Constants, field layouts and types of the three timer/counter unit.
// Assumes: One core clock; a machine cycle is twelve core clocks.
// Notes:   Register offsets are byte addresses on the plain register port.
// What this block does
// - Source bit and mode field steer timers A, B
// - Mode register: B upper nibble, A lower
// - Mode 00: 13-bit count, five-bit prescaler
// - Mode 00 keeps low byte top bits untouched
// - Rollover to zero sets overflow flag
// - Count needs run bit and gate clear or pin high
// - Setting run bit leaves counts unchanged
// - Mode 01: full 16-bit cascaded counter
// - Mode 10: low byte reloads from high byte
// - Timer B mode 11 holds its count
// - Timer A mode 11 splits into two bytes
// - Timer B then runs by mode, no flag
// - Overflow flags at bits 7 and 5
// - Run bits at control bits 6 and 4
// - Pin edge flags at bits 3 and 1
// - Trigger type bits at bits 2 and 0
// - Source bit selects dedicated count pin
// - Timer C: timer or counter, three modes
// - Capture mode: 16-bit count sets overflow flag
// - Trigger fall captures count, sets trigger flag
// - Reload mode: rollover reloads from preset pair
// - Trigger fall also forces reload, sets flag
// - Timer function counts once per machine cycle
// - Pin sampled per machine cycle, high-low counts
// - Timer C overflow flag stays until cleared
// - Timer C runs only with run bit

package ttcu_pkg;

  // Machine cycle length in core clocks.
  localparam int unsigned MCYCLE_CLKS = 12;
  localparam logic [3:0]  MCYCLE_LAST = 4'(MCYCLE_CLKS - 1);

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_MODE    = 8'h01;
  localparam logic [7:0] ADDR_A_LO    = 8'h02;
  localparam logic [7:0] ADDR_A_HI    = 8'h03;
  localparam logic [7:0] ADDR_B_LO    = 8'h04;
  localparam logic [7:0] ADDR_B_HI    = 8'h05;
  localparam logic [7:0] ADDR_C_CTRL  = 8'h06;
  localparam logic [7:0] ADDR_C_LO    = 8'h07;
  localparam logic [7:0] ADDR_C_HI    = 8'h08;
  localparam logic [7:0] ADDR_CAP_LO  = 8'h09;
  localparam logic [7:0] ADDR_CAP_HI  = 8'h0A;

  // Values after reset.
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;

  // Operating modes of timers A and B.
  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} ttcu_tmode_t;

  // Run and flag control register, bit 7 first.
  typedef struct packed {
    logic second_timer_overflow_flag;
    logic second_timer_run;
    logic first_timer_overflow_flag;
    logic first_timer_run;
    logic ext_irq_b_edge_flag;
    logic ext_irq_b_trigger_type;
    logic ext_irq_a_edge_flag;
    logic ext_irq_a_trigger_type;
  } ttcu_ctrl_t;

  // One nibble of the mode select register.
  typedef struct packed {
    logic gate;
    logic count_source_select;
    logic mode_bit_high;
    logic mode_bit_low;
  } ttcu_nib_t;

  typedef struct packed {
    ttcu_nib_t second;
    ttcu_nib_t first;
  } ttcu_mode_t;

  // Third timer control register, bit 7 first.
  typedef struct packed {
    logic third_overflow_flag;
    logic third_trigger_flag;
    logic uart_rx_baud_source;
    logic uart_tx_baud_source;
    logic third_trigger_enable;
    logic third_timer_run;
    logic third_count_source_select;
    logic capture_select;
  } ttcu_cctrl_t;

  // Vector acknowledges from the interrupt logic.
  typedef struct packed {
    logic second_timer;
    logic ext_irq_b;
    logic first_timer;
    logic ext_irq_a;
  } ttcu_ack_t;

  // Request flags handed to the interrupt logic.
  typedef struct packed {
    logic second_timer;
    logic ext_irq_b;
    logic first_timer;
    logic ext_irq_a;
    logic third_overflow;
    logic third_trigger;
  } ttcu_req_t;

endpackage : ttcu_pkg

// ===== design/ttcu_top.sv
// Purpose: Three timer/counters with mode, control and capture registers.
// Assumes: Pins are asynchronous; acknowledges come from the same clock.
// Notes:   Software writes to count bytes win over counting in that cycle.
//
// Strobed register access and the register offsets are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module ttcu_top
  import ttcu_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       EXT_IRQ_A_PIN,
  input  wire logic       EXT_IRQ_B_PIN,
  input  wire logic       FIRST_COUNT_PIN,
  input  wire logic       SECOND_COUNT_PIN,
  input  wire logic       THIRD_COUNT_PIN,
  input  wire logic       THIRD_TIMER_TRIGGER_PIN,
  input  wire ttcu_ack_t  VECTOR_ACK,
  output ttcu_req_t       IRQ_FLAGS,
  output logic            SECOND_OVF_TICK,
  output logic            THIRD_OVF_TICK
);

  // ---------------------------------------------------------------
  // Step functions
  // ---------------------------------------------------------------

  // Mode field of one nibble as a mode value.
  function automatic ttcu_tmode_t ttcu_mode_of(input ttcu_nib_t nib);
    return ttcu_tmode_t'({nib.mode_bit_high, nib.mode_bit_low});
  endfunction : ttcu_mode_of

  // One count step of timer A or B; bit 16 is the overflow.
  function automatic logic [16:0] ttcu_step(input ttcu_tmode_t md,
                                            input logic [7:0]  hi,
                                            input logic [7:0]  lo,
                                            input logic        inc);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    logic [16:0] r;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8  = {1'b0, lo} + 9'h001;
    r   = {1'b0, hi, lo};
    if (inc)
    begin
      case (md)
        MODE_13BIT:   r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
        MODE_16BIT:   r = s16;
        MODE_RELOAD8: r = {s8[8], hi, s8[8] ? hi : s8[7:0]};
        default:      r = {s8[8], hi, s8[7:0]};
      endcase
    end
    return r;
  endfunction : ttcu_step

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------

  logic [3:0]  pre_ff;
  logic [5:0]  pin_meta_ff;
  logic [5:0]  pin_sync_ff;
  logic [5:0]  samp_ff;
  logic [5:0]  fall_ff;
  ttcu_ctrl_t  ctrl_ff;
  ttcu_ctrl_t  nxt_ctrl;
  ttcu_mode_t  mode_ff;
  ttcu_cctrl_t cctrl_ff;
  ttcu_cctrl_t nxt_cctrl;
  logic [7:0]  a_lo_ff;
  logic [7:0]  a_hi_ff;
  logic [7:0]  b_lo_ff;
  logic [7:0]  b_hi_ff;
  logic [15:0] c_cnt_ff;
  logic [15:0] cap_ff;
  logic [7:0]  nxt_a_lo;
  logic [7:0]  nxt_a_hi;
  logic [7:0]  nxt_b_lo;
  logic [7:0]  nxt_b_hi;
  logic [15:0] nxt_c_cnt;
  logic [15:0] nxt_cap;
  logic [7:0]  rd_mux;
  logic [7:0]  rdata_ff;
  logic        b_tick_ff;
  logic        c_tick_ff;

  // ---------------------------------------------------------------
  // Machine cycle and pin sampling
  // ---------------------------------------------------------------

  // One tick per machine cycle of twelve clocks.
  wire tick = (pre_ff == MCYCLE_LAST);

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      pre_ff <= 4'h0;
    else
      pre_ff <= tick ? 4'h0 : pre_ff + 4'h1;
  end

  // Pin order: irq A, irq B, count A, count B, count C, trigger.
  wire [5:0] pins = {EXT_IRQ_A_PIN, EXT_IRQ_B_PIN, FIRST_COUNT_PIN,
                     SECOND_COUNT_PIN, THIRD_COUNT_PIN, THIRD_TIMER_TRIGGER_PIN};

  // Two flops per pin; only the second stage feeds any logic.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pin_meta_ff <= 6'h3F;
      pin_sync_ff <= 6'h3F;
    end
    else
    begin
      pin_meta_ff <= pins;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Sample once per machine cycle; a high then a low sample is one
  // falling edge, flagged for a single clock after the tick.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      samp_ff <= 6'h3F;
      fall_ff <= 6'h00;
    end
    else
    begin
      if (tick)
        samp_ff <= pin_sync_ff;
      fall_ff <= tick ? (samp_ff & ~pin_sync_ff) : 6'h00;
    end
  end

  wire irq_a_lvl  = pin_sync_ff[5];
  wire irq_b_lvl  = pin_sync_ff[4];
  wire irq_a_fall = fall_ff[5];
  wire irq_b_fall = fall_ff[4];
  wire a_evt      = fall_ff[3];
  wire b_evt      = fall_ff[2];
  wire c_evt      = fall_ff[1];
  wire trig_fall  = fall_ff[0];

  // ---------------------------------------------------------------
  // Register strobes
  // ---------------------------------------------------------------

  wire wr_ctrl   = REG_WR & (REG_ADDR == ADDR_CTRL);
  wire wr_mode   = REG_WR & (REG_ADDR == ADDR_MODE);
  wire wr_a_lo   = REG_WR & (REG_ADDR == ADDR_A_LO);
  wire wr_a_hi   = REG_WR & (REG_ADDR == ADDR_A_HI);
  wire wr_b_lo   = REG_WR & (REG_ADDR == ADDR_B_LO);
  wire wr_b_hi   = REG_WR & (REG_ADDR == ADDR_B_HI);
  wire wr_cctrl  = REG_WR & (REG_ADDR == ADDR_C_CTRL);
  wire wr_c_lo   = REG_WR & (REG_ADDR == ADDR_C_LO);
  wire wr_c_hi   = REG_WR & (REG_ADDR == ADDR_C_HI);
  wire wr_cap_lo = REG_WR & (REG_ADDR == ADDR_CAP_LO);
  wire wr_cap_hi = REG_WR & (REG_ADDR == ADDR_CAP_HI);

  // ---------------------------------------------------------------
  // Timers A and B
  // ---------------------------------------------------------------

  wire ttcu_tmode_t mode_a = ttcu_mode_of(mode_ff.first);
  wire ttcu_tmode_t mode_b = ttcu_mode_of(mode_ff.second);
  wire split_a = (mode_a == MODE_SPLIT);

  // Run qualifier: run bit and either no gating or the irq pin high.
  wire run_a = ctrl_ff.first_timer_run & (~mode_ff.first.gate | irq_a_lvl);

  // In split mode the run bit of B belongs to the high byte of A, so B
  // is started and stopped by leaving or entering its mode 11, and by the irq B pin when its gate bit is set.
  wire run_b = (mode_b != MODE_SPLIT)
             & (split_a | ctrl_ff.second_timer_run)
             & (~mode_ff.second.gate | irq_b_lvl);

  // Machine cycles or pin edges, per source select.
  wire inc_a = run_a & (mode_ff.first.count_source_select ? a_evt : tick);
  wire inc_b = run_b & (mode_ff.second.count_source_select ? b_evt : tick);

  wire [16:0] step_a = ttcu_step(mode_a, a_hi_ff, a_lo_ff, inc_a);
  wire [16:0] step_b = ttcu_step(mode_b, b_hi_ff, b_lo_ff, inc_b);

  // Split high byte counts machine cycles under the run bit of B.
  wire       inc_ah  = split_a & ctrl_ff.second_timer_run & tick;
  wire [8:0] ah_sum  = {1'b0, a_hi_ff} + 9'h001;
  wire       ah_ovf  = inc_ah & ah_sum[8];

  wire ovf_a = step_a[16];
  wire ovf_b = step_b[16];

  // Overflow flag of B comes from the split high byte when A is split.
  wire set_flag_b = split_a ? ah_ovf : ovf_b;

  // Count bytes: a software write takes the cycle, otherwise step.
  // A run-bit write never touches them.
  assign nxt_a_lo = wr_a_lo ? REG_WDATA : step_a[7:0];
  assign nxt_a_hi = wr_a_hi ? REG_WDATA
                  : split_a ? (inc_ah ? ah_sum[7:0] : a_hi_ff)
                  : step_a[15:8];
  assign nxt_b_lo = wr_b_lo ? REG_WDATA : step_b[7:0];
  assign nxt_b_hi = wr_b_hi ? REG_WDATA : step_b[15:8];

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      a_lo_ff <= RST_BYTE;
      a_hi_ff <= RST_BYTE;
      b_lo_ff <= RST_BYTE;
      b_hi_ff <= RST_BYTE;
      mode_ff <= RST_BYTE;
    end
    else
    begin
      a_lo_ff <= nxt_a_lo;
      a_hi_ff <= nxt_a_hi;
      b_lo_ff <= nxt_b_lo;
      b_hi_ff <= nxt_b_hi;
      if (wr_mode)
        mode_ff <= REG_WDATA;
    end
  end

  // ---------------------------------------------------------------
  // Run and flag control register
  // ---------------------------------------------------------------

  // Writes and vector acknowledges clear; hardware sets win over both
  // so an overflow in the clearing cycle is never lost.
  always_comb
  begin
    nxt_ctrl = wr_ctrl ? ttcu_ctrl_t'(REG_WDATA) : ctrl_ff;
    if (VECTOR_ACK.second_timer)
      nxt_ctrl.second_timer_overflow_flag = 1'b0;
    if (VECTOR_ACK.first_timer)
      nxt_ctrl.first_timer_overflow_flag = 1'b0;
    if (VECTOR_ACK.ext_irq_b)
      nxt_ctrl.ext_irq_b_edge_flag = 1'b0;
    if (VECTOR_ACK.ext_irq_a)
      nxt_ctrl.ext_irq_a_edge_flag = 1'b0;
    if (set_flag_b)
      nxt_ctrl.second_timer_overflow_flag = 1'b1;
    if (ovf_a)
      nxt_ctrl.first_timer_overflow_flag = 1'b1;
    // Edge type latches a sampled fall; level type follows a low pin.
    if (ctrl_ff.ext_irq_b_trigger_type)
    begin
      if (irq_b_fall)
        nxt_ctrl.ext_irq_b_edge_flag = 1'b1;
    end
    else if (tick)
      nxt_ctrl.ext_irq_b_edge_flag = ~samp_ff[4];
    if (ctrl_ff.ext_irq_a_trigger_type)
    begin
      if (irq_a_fall)
        nxt_ctrl.ext_irq_a_edge_flag = 1'b1;
    end
    else if (tick)
      nxt_ctrl.ext_irq_a_edge_flag = ~samp_ff[5];
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      ctrl_ff <= RST_BYTE;
    else
      ctrl_ff <= nxt_ctrl;
  end

  // ---------------------------------------------------------------
  // Timer C
  // ---------------------------------------------------------------

  // Baud generation forces reload and keeps the overflow flag quiet;
  // the serial side itself lies outside this block.
  wire baud_c   = cctrl_ff.uart_rx_baud_source | cctrl_ff.uart_tx_baud_source;
  wire cap_mode = cctrl_ff.capture_select & ~baud_c;
  wire inc_c    = cctrl_ff.third_timer_run
                & (cctrl_ff.third_count_source_select ? c_evt : tick);
  wire ovf_c    = inc_c & (c_cnt_ff == WORD_MAX);
  wire trig_c   = cctrl_ff.third_trigger_enable & trig_fall;

  wire [15:0] c_sum = c_cnt_ff + 16'h0001;

  // Reload on rollover or trigger outside capture mode.
  wire reload_c = ~cap_mode & (ovf_c | trig_c);
  wire [15:0] c_run = reload_c ? cap_ff : (inc_c ? c_sum : c_cnt_ff);

  assign nxt_c_cnt = {wr_c_hi ? REG_WDATA : c_run[15:8],
                      wr_c_lo ? REG_WDATA : c_run[7:0]};

  // Capture pair: software preset, or count caught on a trigger fall.
  wire [15:0] cap_hw = (cap_mode & trig_c) ? c_cnt_ff : cap_ff;
  assign nxt_cap = {wr_cap_hi ? REG_WDATA : cap_hw[15:8],
                    wr_cap_lo ? REG_WDATA : cap_hw[7:0]};

  // Flags are cleared only by software; hardware sets win.
  always_comb
  begin
    nxt_cctrl = wr_cctrl ? ttcu_cctrl_t'(REG_WDATA) : cctrl_ff;
    if (ovf_c & ~baud_c)
      nxt_cctrl.third_overflow_flag = 1'b1;
    if (trig_c)
      nxt_cctrl.third_trigger_flag = 1'b1;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cctrl_ff <= RST_BYTE;
      c_cnt_ff <= RST_WORD;
      cap_ff   <= RST_WORD;
    end
    else
    begin
      cctrl_ff <= nxt_cctrl;
      c_cnt_ff <= nxt_c_cnt;
      cap_ff   <= nxt_cap;
    end
  end

  // ---------------------------------------------------------------
  // Read path and outputs
  // ---------------------------------------------------------------

  // Read mux; unmapped addresses read as zero.
  always_comb
  begin
    if (REG_ADDR == ADDR_CTRL)
      rd_mux = ctrl_ff;
    else if (REG_ADDR == ADDR_MODE)
      rd_mux = mode_ff;
    else if (REG_ADDR == ADDR_A_LO)
      rd_mux = a_lo_ff;
    else if (REG_ADDR == ADDR_A_HI)
      rd_mux = a_hi_ff;
    else if (REG_ADDR == ADDR_B_LO)
      rd_mux = b_lo_ff;
    else if (REG_ADDR == ADDR_B_HI)
      rd_mux = b_hi_ff;
    else if (REG_ADDR == ADDR_C_CTRL)
      rd_mux = cctrl_ff;
    else if (REG_ADDR == ADDR_C_LO)
      rd_mux = c_cnt_ff[7:0];
    else if (REG_ADDR == ADDR_C_HI)
      rd_mux = c_cnt_ff[15:8];
    else if (REG_ADDR == ADDR_CAP_LO)
      rd_mux = cap_ff[7:0];
    else if (REG_ADDR == ADDR_CAP_HI)
      rd_mux = cap_ff[15:8];
    else
      rd_mux = RST_BYTE;
  end

  // Read data stands only in the cycle after the strobe.
  // Overflow ticks feed serial baud timing whatever the flags do.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rdata_ff  <= RST_BYTE;
      b_tick_ff <= 1'b0;
      c_tick_ff <= 1'b0;
    end
    else
    begin
      rdata_ff  <= REG_RD ? rd_mux : RST_BYTE;
      b_tick_ff <= ovf_b;
      c_tick_ff <= ovf_c;
    end
  end

  assign REG_RDATA       = rdata_ff;
  assign SECOND_OVF_TICK = b_tick_ff;
  assign THIRD_OVF_TICK  = c_tick_ff;
  assign IRQ_FLAGS       = '{second_timer:   ctrl_ff.second_timer_overflow_flag,
                             ext_irq_b:      ctrl_ff.ext_irq_b_edge_flag,
                             first_timer:    ctrl_ff.first_timer_overflow_flag,
                             ext_irq_a:      ctrl_ff.ext_irq_a_edge_flag,
                             third_overflow: cctrl_ff.third_overflow_flag,
                             third_trigger:  cctrl_ff.third_trigger_flag};

endmodule : ttcu_top

`default_nettype wire

// ===== dv/test_three_timer_counter_unit.sv
// Purpose: Self-checking bench of the three timer/counter unit.
// Assumes: Reads are compared from a queue in the cycle after the strobe.
// Notes:   Most scenarios start from a fresh reset.

`timescale 1ns/1ps
`default_nettype none

module test_three_timer_counter_unit
  import ttcu_pkg::*;
;
  //--------------------------------------------------------------------
  // Stimulus and checks
  //--------------------------------------------------------------------
  logic       CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, rd_d = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, r1, r2;
  logic [5:0] low_req = 6'h00, pins;
  ttcu_ack_t  VECTOR_ACK = 4'h0;
  ttcu_req_t  IRQ_FLAGS;
  logic       SECOND_OVF_TICK, THIRD_OVF_TICK;
  logic [7:0] exp_q [$];
  int         bad_count = 0, n_compared = 0, seed = 32'h74F9;

  ttcu_top u_dut (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EXT_IRQ_A_PIN(pins[0]),
    .EXT_IRQ_B_PIN(pins[1]), .FIRST_COUNT_PIN(pins[2]), .SECOND_COUNT_PIN(pins[3]),
    .THIRD_COUNT_PIN(pins[4]), .THIRD_TIMER_TRIGGER_PIN(pins[5]), .VECTOR_ACK(VECTOR_ACK),
    .IRQ_FLAGS(IRQ_FLAGS), .SECOND_OVF_TICK(SECOND_OVF_TICK), .THIRD_OVF_TICK(THIRD_OVF_TICK));
  ttcu_pin_model u_pins (.clk(CLK), .low_req(low_req), .pins(pins));

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic cmp8(string what, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (s !== e)
    begin
      $display("unexpected %s: expected %h, seen %h", what, e, s);
      bad_count++;
    end
  endtask : cmp8

  task automatic cmp1(string what, logic e, logic s);
    n_compared++;
    if (s !== e)
    begin
      $display("unexpected %s: expected %b, seen %b", what, e, s);
      bad_count++;
    end
  endtask : cmp1

  task automatic rst();
    @(posedge CLK);
    RST <= 1'b1;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
  endtask : rst

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr

  // The expectation is queued; the monitor below takes it off.
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    exp_q.push_back(e);
    @(posedge CLK);
    REG_RD <= 1'b0;
  endtask : rd

  // Bounded wait, so a flag that never rises shows as a mismatch.
  // It returns at the first falling edge with the flag up, while a
  // one-clock overflow tick set at the same edge still stands.
  task automatic wait_flag(int idx);
    for (int i = 0; i < 100; i++)
    begin
      @(negedge CLK);
      if (IRQ_FLAGS[idx] === 1'b1) break;
    end
    cmp1("request flag", 1'b1, IRQ_FLAGS[idx]);
  endtask : wait_flag

  // Each level lasts twenty clocks, beyond a machine cycle plus sync.
  task automatic pulse(int idx);
    @(posedge CLK);
    low_req[idx] <= 1'b1;
    repeat (20) @(posedge CLK);
    low_req[idx] <= 1'b0;
    repeat (20) @(posedge CLK);
  endtask : pulse

  initial forever #2 CLK = ~CLK;

  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge CLK) rd_d <= REG_RD;
  always @(negedge CLK)
    if (rd_d === 1'b1) cmp8("read data", exp_q.pop_front(), REG_RDATA);

  initial
  begin
    #40000;
    bad_count++;
    finish_test();
  end

  initial
  begin
    rst();
    for (int a = 0; a < 12; a++) rd(8'(a), 8'h00);
    wr(8'h0B, 8'hFF);
    rd(8'h0B, 8'h00);
    r1 = 8'($random(seed));
    wr(ADDR_MODE, r1);
    rd(ADDR_MODE, r1);
    wr(ADDR_CTRL, 8'h05);
    rd(ADDR_CTRL, 8'h05);
    // Thirteen-bit mode: prescaler carries into the high byte.
    rst();
    wr(ADDR_A_LO, {r1[2:0], 5'h1E});
    wr(ADDR_A_HI, 8'hFF);
    wr(ADDR_CTRL, 8'h10);
    wait_flag(3);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_A_HI, 8'h00);
    rd(ADDR_A_LO, {r1[2:0], 5'h00});
    // Sixteen-bit rollover, then the vector acknowledge clears the flag.
    rst();
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_A_LO, 8'hFF);
    wr(ADDR_A_HI, 8'hFF);
    wr(ADDR_CTRL, 8'h10);
    wait_flag(3);
    @(posedge CLK);
    VECTOR_ACK <= 4'h2;
    @(posedge CLK);
    VECTOR_ACK <= 4'h0;
    @(negedge CLK);
    cmp1("flag after ack", 1'b0, IRQ_FLAGS.first_timer);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_A_LO, 8'h00);
    rd(ADDR_A_HI, 8'h00);
    // Timer B eight-bit reload and its exported tick.
    rst();
    wr(ADDR_MODE, 8'h20);
    wr(ADDR_B_HI, r1);
    wr(ADDR_B_LO, 8'hFF);
    wr(ADDR_CTRL, 8'h40);
    wait_flag(5);
    cmp1("B tick", 1'b1, SECOND_OVF_TICK);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_B_LO, r1);
    rd(ADDR_B_HI, r1);
    // Gate pin low holds timer A; its fall raises the edge flag.
    rst();
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_A_LO, 8'h05);
    low_req[0] <= 1'b1;
    repeat (4) @(posedge CLK);
    wr(ADDR_CTRL, 8'h11);
    repeat (48) @(negedge CLK);
    cmp1("edge flag", 1'b1, IRQ_FLAGS.ext_irq_a);
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_A_LO, 8'h05);
    // Level type: the flag follows the low pin at the next tick.
    wr(ADDR_CTRL, 8'h00);
    repeat (30) @(negedge CLK);
    cmp1("level flag", 1'b1, IRQ_FLAGS.ext_irq_a);
    low_req[0] <= 1'b0;
    // Counter function counts falls on the dedicated pin.
    rst();
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_CTRL, 8'h10);
    for (int i = 0; i < 3; i++) pulse(2);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_A_LO, 8'h03);
    // Split mode: high byte of A runs on B's run bit; B is held.
    rst();
    wr(ADDR_MODE, 8'h33);
    wr(ADDR_A_HI, 8'hFF);
    wr(ADDR_B_LO, 8'h10);
    wr(ADDR_CTRL, 8'h40);
    wait_flag(5);
    cmp1("B tick", 1'b0, SECOND_OVF_TICK);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_A_LO, 8'h00);
    rd(ADDR_B_LO, 8'h10);
    // Timer C: capture on trigger fall, then forced reload, then rollover.
    rst();
    r2 = 8'($random(seed));
    wr(ADDR_C_LO, r1);
    wr(ADDR_C_HI, r2);
    wr(ADDR_C_CTRL, 8'h09);
    pulse(5);
    rd(ADDR_CAP_LO, r1);
    rd(ADDR_CAP_HI, r2);
    rd(ADDR_C_CTRL, 8'h49);
    wr(ADDR_C_CTRL, 8'h08);
    wr(ADDR_CAP_LO, r2);
    wr(ADDR_CAP_HI, r1);
    pulse(5);
    rd(ADDR_C_LO, r2);
    rd(ADDR_C_HI, r1);
    rd(ADDR_C_CTRL, 8'h48);
    wr(ADDR_C_LO, 8'hFF);
    wr(ADDR_C_HI, 8'hFF);
    wr(ADDR_C_CTRL, 8'h04);
    wait_flag(1);
    cmp1("C tick", 1'b1, THIRD_OVF_TICK);
    wr(ADDR_C_CTRL, 8'h80);
    rd(ADDR_C_LO, r2);
    rd(ADDR_C_HI, r1);
    rd(ADDR_C_CTRL, 8'h80);
    repeat (4) @(posedge CLK);
    finish_test();
  end
endmodule : test_three_timer_counter_unit

`default_nettype wire

// ===== dv/ttcu_pin_model.sv
// Purpose: Far-side model of the event, gate and trigger pins.
// Assumes: Pins idle high behind pull-ups.
// Notes:   Order: irq A, irq B, count A, count B, count C, trigger.

`timescale 1ns/1ps
`default_nettype none

module ttcu_pin_model
(
  input  wire logic       clk,
  input  wire logic [5:0] low_req,
  output logic      [5:0] pins = 6'h3F
);
  //--------------------------------------------------------------------
  // Pin drivers
  //--------------------------------------------------------------------
  logic [4:0] hold_ff [6] = '{default: 5'h00};

  // A level is kept sixteen clocks, so a slow sampler never misses it.
  always @(posedge clk)
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (hold_ff[i] != 5'h00) hold_ff[i] <= hold_ff[i] - 5'h01;
      else if (pins[i] == low_req[i])
      begin
        pins[i] <= ~low_req[i];
        hold_ff[i] <= 5'h10;
      end
    end
  end
endmodule : ttcu_pin_model

`default_nettype wire

// ===== dv/ttcu_properties.sv
// Purpose: Concurrent checks on the ports of the timer unit.
// Assumes: One-cycle strobes; read data in the cycle after the read.
// Notes:   Count values are judged by the bench; these judge read-back, flag places and tick timing.

`timescale 1ns/1ps
`default_nettype none

module ttcu_properties
  import ttcu_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       EXT_IRQ_A_PIN,
  input wire logic       EXT_IRQ_B_PIN,
  input wire logic       FIRST_COUNT_PIN,
  input wire logic       SECOND_COUNT_PIN,
  input wire logic       THIRD_COUNT_PIN,
  input wire logic       THIRD_TIMER_TRIGGER_PIN,
  input wire ttcu_ack_t  VECTOR_ACK,
  input wire ttcu_req_t  IRQ_FLAGS,
  input wire logic       SECOND_OVF_TICK,
  input wire logic       THIRD_OVF_TICK
);
  //--------------------------------------------------------------------
  // Properties
  //--------------------------------------------------------------------
  // Everything runs on the core clock and is muted during reset.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_rst_clears_out: assert property ($fell(RST) |-> IRQ_FLAGS == 6'h00 && REG_RDATA == 8'h00)
    else $error("outputs not clear after reset");
  a_mode_reads_back: assert property (REG_WR && REG_ADDR == ADDR_MODE ##2 REG_RD && REG_ADDR == ADDR_MODE |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("mode register lost its value");
  a_ctrl_soft_bits: assert property (REG_WR && REG_ADDR == ADDR_CTRL ##2 REG_RD && REG_ADDR == ADDR_CTRL |=> (REG_RDATA & 8'h55) == ($past(REG_WDATA, 3) & 8'h55))
    else $error("run or type bits lost");
  a_ovf_flag_place: assert property (REG_RD && REG_ADDR == ADDR_CTRL |=> REG_RDATA[7] == $past(IRQ_FLAGS.second_timer) && REG_RDATA[5] == $past(IRQ_FLAGS.first_timer))
    else $error("overflow flags misplaced");
  a_edge_flag_place: assert property (REG_RD && REG_ADDR == ADDR_CTRL |=> REG_RDATA[3] == $past(IRQ_FLAGS.ext_irq_b) && REG_RDATA[1] == $past(IRQ_FLAGS.ext_irq_a))
    else $error("edge flags misplaced");
  a_third_flag_place: assert property (REG_RD && REG_ADDR == ADDR_C_CTRL |=> REG_RDATA[7:6] == $past(IRQ_FLAGS[1:0]))
    else $error("third timer flags misplaced");
  a_b_tick_single: assert property (SECOND_OVF_TICK |=> !SECOND_OVF_TICK [*8])
    else $error("timer B tick too long or too close");
  a_c_tick_single: assert property (THIRD_OVF_TICK |=> !THIRD_OVF_TICK [*8])
    else $error("timer C tick too long or too close");

  c_b_tick: cover property (SECOND_OVF_TICK);
  c_c_tick: cover property (THIRD_OVF_TICK);
  c_trigger: cover property (IRQ_FLAGS.third_trigger);
endmodule : ttcu_properties

bind ttcu_top ttcu_properties u_props (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .EXT_IRQ_A_PIN(EXT_IRQ_A_PIN), .EXT_IRQ_B_PIN(EXT_IRQ_B_PIN),
  .FIRST_COUNT_PIN(FIRST_COUNT_PIN), .SECOND_COUNT_PIN(SECOND_COUNT_PIN),
  .THIRD_COUNT_PIN(THIRD_COUNT_PIN), .THIRD_TIMER_TRIGGER_PIN(THIRD_TIMER_TRIGGER_PIN),
  .VECTOR_ACK(VECTOR_ACK), .IRQ_FLAGS(IRQ_FLAGS), .SECOND_OVF_TICK(SECOND_OVF_TICK),
  .THIRD_OVF_TICK(THIRD_OVF_TICK));

`default_nettype wire
